// [core/lsf_ladder_unit.sv]
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// [RULE_01] open contact passes on bit ON, closed contact passes on bit OFF
// [RULE_02] inversion complements the accumulated rung condition
// [RULE_03] series contacts combine as AND
// [RULE_04] parallel branches combine as OR
// [RULE_05] instructions run strictly in program order each scan
// [RULE_06] latch-on sets bit when true and keeps it set
// [RULE_07] latch-off clears bit when true and keeps it clear
// [RULE_08] rising pulse is ON for one scan after OFF-to-ON
// [RULE_09] falling pulse is ON for one scan after ON-to-OFF
// [RULE_10] eight master gates, 0 to 7, inner gates nest in outer
// [RULE_11] an OFF outer gate forces all inner gates OFF
// [RULE_12] gated off: outputs OFF, latches hold, timers reload, counters hold
// [RULE_13] sixteen step relays, step numbers 0 to 255, one byte each
// [RULE_14] step advance sets n only if n-1 is ON, then clears n-1
// [RULE_15] selecting step zero resets the relay to step zero
// [RULE_16] exclusive select keeps only the latest selected step active
// [RULE_17] on-delay runs while input ON, done at preset, reloads when OFF
// [RULE_18] fine timers tick 0.01 s, coarse 0.1 s, 16-bit presets
// [RULE_19] off-delay output ON at once, held preset time after input falls
// [RULE_20] off-delay value counts down each tick, output OFF at zero
// [RULE_21] ordinary timers clear at reset, retentive timers keep values
// [RULE_22] up counter counts up, done at preset, reset to zero
// [RULE_23] down counter counts down, done at zero, reset reloads preset
// [RULE_24] the program is scanned once every 10 ms
// [RULE_25] counters count once per OFF-to-ON of the count input
// [RULE_26] timer ticks come from prescalers, one step per tick at most
module lsf_ladder_unit
  import lsf_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES   = SCAN_CYC,
  parameter int unsigned FINE_CYCLES   = FINE_CYC,
  parameter int unsigned COARSE_CYCLES = COARSE_CYC
)(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [15:0]       addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output      logic [31:0]       rdata,
  // pins
  input  wire logic [PIN_N-1:0]  pin_in,
  output      logic [PIN_N-1:0]  pin_out,
  // status
  output      logic              scan_busy
);

  // ****************************
  // state and memories
  // ****************************
  lsf_state_t  s_r;
  lsf_state_t  s_nxt;
  lsf_bus_t    bus;
  logic [31:0] prog_mem [PROG_N];
  logic [15:0] tmr_mem [TMR_N];
  logic        tw_en;
  logic [3:0]  tw_idx;
  logic [15:0] tw_val;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ****************************
  // program and timer memories
  // ****************************
  always_ff @(posedge mclk)
  begin
    if (bus.wr && bus.addr[15:10] == PAGE_PROG)
    begin
      prog_mem[bus.addr[9:2]] <= bus.wdata;
    end
    // [RULE_21] no reset on values
    if (tw_en)
    begin
      tmr_mem[tw_idx] <= tw_val;
    end
  end

  // ****************************
  // next state
  // ****************************
  always_comb
  begin
    logic [31:0] ins;
    lsf_op_t     op;
    logic [10:0] idx;
    logic [15:0] aux;
    logic [3:0]  t;
    logic        opnd;
    logic        en;
    logic        tick;
    logic        cur_ok;
    logic [15:0] cur;
    logic        scan_tick;
    logic        fine_tick;
    logic        coarse_tick;
    ins         = prog_mem[s_r.pc];
    op          = lsf_op_t'(ins[OPC_HI:OPC_LO]);
    idx         = ins[IDX_HI:IDX_LO];
    aux         = ins[15:0];
    t           = idx[3:0];
    en          = &s_r.gate;
    tick        = 1'b0;
    cur_ok      = 1'b0;
    cur         = 16'h0000;
    s_nxt       = s_r;
    tw_en       = 1'b0;
    tw_idx      = t;
    tw_val      = 16'h0000;
    s_nxt.pin_s1 = pin_in;
    s_nxt.pin_s2 = s_r.pin_s1;

    // operand fetch
    // [RULE_01] contact operand
    unique case (idx[10:9])
      REG_TMR:  opnd = idx[4] ? s_r.cdone[t] : s_r.tdone[t];
      REG_STEP: opnd = s_r.son[t] && s_r.snum[t] == aux[7:0];
      default:  opnd = s_r.bits[idx[8:0]];
    endcase

    // [RULE_24] [RULE_26] prescalers
    scan_tick   = s_r.scan_div == SCAN_CYCLES - 1;
    fine_tick   = s_r.fine_div == FINE_CYCLES - 1;
    coarse_tick = s_r.coarse_div == COARSE_CYCLES - 1;
    s_nxt.scan_div   = scan_tick ? 32'h0 : s_r.scan_div + 32'h1;
    s_nxt.fine_div   = fine_tick ? 32'h0 : s_r.fine_div + 32'h1;
    s_nxt.coarse_div = coarse_tick ? 32'h0 : s_r.coarse_div + 32'h1;

    // register writes
    if (bus.wr)
    begin
      if (bus.addr == ADDR_CTRL)
      begin
        s_nxt.run = bus.wdata[CTRL_RUN];
      end
      else if (bus.addr[15:10] == PAGE_BITS && !bus.addr[9])
      begin
        s_nxt.bits[{bus.addr[6:2], 4'h0} +: 16] = bus.wdata[15:0];
      end
    end

    // register reads
    s_nxt.rdata = 32'h0000_0000;
    if (bus.rd)
    begin
      if (bus.addr == ADDR_CTRL)
        s_nxt.rdata = {31'h0, s_r.run};
      else if (bus.addr == ADDR_STATUS)
        s_nxt.rdata = {s_r.scans, 15'h0, s_r.st != ST_IDLE};
      else if (bus.addr[15:10] == PAGE_PROG)
        s_nxt.rdata = prog_mem[bus.addr[9:2]];
      else if (bus.addr[15:10] == PAGE_BITS && !bus.addr[9])
        s_nxt.rdata = {16'h0, s_r.bits[{bus.addr[6:2], 4'h0} +: 16]};
      else if (bus.addr[15:8] == PAGE_TMR && bus.addr[7:6] == 2'h0)
        s_nxt.rdata = {15'h0, s_r.tdone[bus.addr[5:2]], tmr_mem[bus.addr[5:2]]};
      else if (bus.addr[15:8] == PAGE_CNT && bus.addr[7:6] == 2'h0)
        s_nxt.rdata = {15'h0, s_r.cdone[bus.addr[5:2]], s_r.cval[bus.addr[5:2]]};
      else if (bus.addr[15:8] == PAGE_STEP && bus.addr[7:6] == 2'h0)
        s_nxt.rdata = {23'h0, s_r.son[bus.addr[5:2]], s_r.snum[bus.addr[5:2]]};
    end

    // scan sequencer
    unique case (s_r.st)
      ST_IDLE:
      begin
        if (s_r.scan_pend)
        begin
          s_nxt.scan_pend = 1'b0;
          s_nxt.st = ST_LATCH;
        end
      end
      ST_LATCH:
      begin
        s_nxt.bits[PIN_N-1:0] = s_r.pin_s2;
        s_nxt.gate = '1;
        s_nxt.pc   = '0;
        s_nxt.acc  = 1'b0;
        s_nxt.blk  = 1'b0;
        s_nxt.st   = ST_EXEC;
      end
      ST_EXEC:
      begin
        // [RULE_05] one instruction per cycle, in order
        s_nxt.pc = s_r.pc + 1'b1;
        if (op == OP_END || s_r.pc == PC_W'(PROG_N - 1))
        begin
          s_nxt.st = ST_FINISH;
        end
        unique case (op)
          OP_END: ;
          // [RULE_01] contact tests
          OP_LOAD:                s_nxt.acc = opnd;
          OP_CLOSED_CONTACT_TEST: s_nxt.acc = !opnd;
          // [RULE_03] series AND
          OP_AND:                 s_nxt.acc = s_r.acc & opnd;
          OP_AND_NOT:             s_nxt.acc = s_r.acc & !opnd;
          // [RULE_04] parallel OR
          OP_OR:                  s_nxt.acc = s_r.acc | opnd;
          OP_OR_NOT:              s_nxt.acc = s_r.acc | !opnd;
          // [RULE_02] inversion
          OP_NOT:                 s_nxt.acc = !s_r.acc;
          OP_SAVE:                s_nxt.blk = s_r.acc;
          OP_AND_BLOCK:           s_nxt.acc = s_r.acc & s_r.blk;
          // [RULE_04] block OR
          OP_OR_BLOCK:            s_nxt.acc = s_r.acc | s_r.blk;
          // [RULE_12] plain output forced off
          OP_OUT:                 s_nxt.bits[idx[8:0]] = s_r.acc & en;
          // [RULE_06] latch on
          OP_LATCH_OUTPUT_ON:
          begin
            if (en && s_r.acc)
              s_nxt.bits[idx[8:0]] = 1'b1;
          end
          // [RULE_07] latch off
          OP_LATCH_OUTPUT_OFF:
          begin
            if (en && s_r.acc)
              s_nxt.bits[idx[8:0]] = 1'b0;
          end
          // [RULE_08] [RULE_09] one-scan pulses
          OP_RISING_PULSE, OP_FALLING_PULSE:
          begin
            if (en)
            begin
              s_nxt.prev[s_r.pc] = s_r.acc;
              s_nxt.acc = (op == OP_RISING_PULSE) ? (s_r.acc & !s_r.prev[s_r.pc])
                                                  : (!s_r.acc & s_r.prev[s_r.pc]);
            end
            else
              s_nxt.acc = 1'b0;
          end
          // [RULE_10] [RULE_11] gate opens under its outers
          OP_MASTER_GATE_BEGIN:   s_nxt.gate[idx[2:0]] = s_r.acc;
          OP_MASTER_GATE_END:
          begin
            for (int g = 0; g < GATE_N; g++)
              if (g >= idx[2:0])
                s_nxt.gate[g] = 1'b1;
          end
          // [RULE_13] [RULE_14] [RULE_15] step advance
          OP_SEQUENTIAL_STEP_ADVANCE:
          begin
            if (en && s_r.acc)
            begin
              if (aux[7:0] == 8'h00)
              begin
                s_nxt.son[t]  = 1'b1;
                s_nxt.snum[t] = 8'h00;
              end
              else if (s_r.son[t] && s_r.snum[t] == aux[7:0] - 8'h01)
                s_nxt.snum[t] = aux[7:0];
            end
          end
          // [RULE_16] exclusive select
          OP_EXCLUSIVE_STEP_SELECT:
          begin
            if (en && s_r.acc)
            begin
              s_nxt.son[t]  = 1'b1;
              s_nxt.snum[t] = aux[7:0];
            end
          end
          // [RULE_17] [RULE_18] [RULE_21] on-delay timers
          OP_ON_DELAY_FINE, OP_ON_DELAY_COARSE,
          OP_RETENTIVE_ON_DELAY_FINE, OP_RETENTIVE_ON_DELAY_COARSE:
          begin
            tick   = (op == OP_ON_DELAY_FINE || op == OP_RETENTIVE_ON_DELAY_FINE)
                     ? s_r.fine_pend : s_r.coarse_pend;
            cur_ok = s_r.tvalid[t] || op == OP_RETENTIVE_ON_DELAY_FINE
                     || op == OP_RETENTIVE_ON_DELAY_COARSE;
            tw_en  = 1'b1;
            s_nxt.tvalid[t] = 1'b1;
            if (!en || !s_r.acc)
            begin
              // [RULE_12] reload preset when gated off
              tw_val = aux;
              s_nxt.tdone[t] = 1'b0;
            end
            else
            begin
              // [RULE_26] one unit per tick
              cur = cur_ok ? tmr_mem[t] : aux;
              if (tick && cur != 16'h0000)
                cur = cur - 16'h0001;
              tw_val = cur;
              s_nxt.tdone[t] = cur == 16'h0000;
            end
          end
          // [RULE_19] [RULE_20] off-delay timers
          OP_OFF_DELAY_FINE, OP_OFF_DELAY_COARSE:
          begin
            tick  = (op == OP_OFF_DELAY_FINE) ? s_r.fine_pend : s_r.coarse_pend;
            tw_en = 1'b1;
            s_nxt.tvalid[t] = 1'b1;
            if (!en)
            begin
              tw_val = aux;
              s_nxt.tdone[t] = 1'b0;
            end
            else if (s_r.acc)
            begin
              tw_val = aux;
              s_nxt.tdone[t] = 1'b1;
            end
            else
            begin
              cur = s_r.tvalid[t] ? tmr_mem[t] : 16'h0000;
              if (tick && cur != 16'h0000)
                cur = cur - 16'h0001;
              tw_val = cur;
              s_nxt.tdone[t] = s_r.tdone[t] && cur != 16'h0000;
            end
          end
          // [RULE_22] [RULE_23] [RULE_25] counters, reset from saved condition
          OP_UP_COUNT_OP, OP_DOWN_COUNT_OP:
          begin
            if (en)
            begin
              s_nxt.cprev[t] = s_r.acc;
              if (s_r.blk)
              begin
                s_nxt.cval[t]  = (op == OP_UP_COUNT_OP) ? 16'h0000 : aux;
                s_nxt.cdone[t] = (op == OP_UP_COUNT_OP) ? (aux == 16'h0000)
                                                        : (aux == 16'h0000);
              end
              else if (s_r.acc && !s_r.cprev[t])
              begin
                if (op == OP_UP_COUNT_OP)
                begin
                  if (s_r.cval[t] != 16'hFFFF)
                    s_nxt.cval[t] = s_r.cval[t] + 16'h0001;
                  s_nxt.cdone[t] = s_nxt.cval[t] >= aux;
                end
                else
                begin
                  if (s_r.cval[t] != 16'h0000)
                    s_nxt.cval[t] = s_r.cval[t] - 16'h0001;
                  s_nxt.cdone[t] = s_nxt.cval[t] == 16'h0000;
                end
              end
            end
          end
          default: ;
        endcase
        tw_idx = t;
      end
      ST_FINISH:
      begin
        s_nxt.pin_out     = s_r.bits[2*PIN_N-1:PIN_N];
        s_nxt.fine_pend   = 1'b0;
        s_nxt.coarse_pend = 1'b0;
        s_nxt.scans       = s_r.scans + 16'h0001;
        s_nxt.st          = ST_IDLE;
      end
    endcase

    // ticks set after the clears so none is lost
    if (fine_tick)
      s_nxt.fine_pend = 1'b1;
    if (coarse_tick)
      s_nxt.coarse_pend = 1'b1;
    // [RULE_24] periodic scan start
    if (scan_tick && s_r.run)
      s_nxt.scan_pend = 1'b1;
    if (bus.wr && bus.addr == ADDR_CTRL && bus.wdata[CTRL_ONCE])
      s_nxt.scan_pend = 1'b1;
  end

  // ****************************
  // state register
  // ****************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r      <= '0;
      s_r.st   <= ST_IDLE;
      s_r.gate <= '1;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata     = s_r.rdata;
  assign pin_out   = s_r.pin_out;
  assign scan_busy = s_r.st != ST_IDLE;

endmodule

// [include/lsf_pkg.sv]
package lsf_pkg;

  // ****************************
  // sizes
  // ****************************
  localparam int PROG_N  = 256;
  localparam int PC_W    = 8;
  localparam int BIT_N   = 512;
  localparam int TMR_N   = 16;
  localparam int CNT_N   = 16;
  localparam int REL_N   = 16;
  localparam int GATE_N  = 8;
  localparam int PIN_N   = 16;

  // ****************************
  // timing
  // ****************************
  localparam int MCLK_MHZ       = 200;
  localparam int SCAN_PERIOD_US = 10000;
  localparam int FINE_TICK_US   = 10000;
  localparam int COARSE_TICK_US = 100000;
  localparam int SCAN_CYC       = SCAN_PERIOD_US * MCLK_MHZ;
  localparam int FINE_CYC       = FINE_TICK_US * MCLK_MHZ;
  localparam int COARSE_CYC     = COARSE_TICK_US * MCLK_MHZ;

  // ****************************
  // register map, byte addresses
  // ****************************
  localparam logic [15:0] ADDR_CTRL   = 16'h0000;
  localparam logic [15:0] ADDR_STATUS = 16'h0004;
  localparam logic [5:0]  PAGE_PROG   = 6'h01;
  localparam logic [5:0]  PAGE_BITS   = 6'h02;
  localparam logic [7:0]  PAGE_TMR    = 8'h0C;
  localparam logic [7:0]  PAGE_CNT    = 8'h0D;
  localparam logic [7:0]  PAGE_STEP   = 8'h0E;
  localparam int          CTRL_RUN    = 0;
  localparam int          CTRL_ONCE   = 1;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // ****************************
  // instruction layout
  // ****************************
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 27;
  localparam int IDX_HI = 26;
  localparam int IDX_LO = 16;
  localparam logic [1:0] REG_TMR  = 2'h2;
  localparam logic [1:0] REG_STEP = 2'h3;

  typedef enum logic [4:0] {
    OP_END, OP_LOAD, OP_CLOSED_CONTACT_TEST, OP_AND, OP_AND_NOT, OP_OR, OP_OR_NOT,
    OP_NOT, OP_SAVE, OP_AND_BLOCK, OP_OR_BLOCK, OP_OUT, OP_LATCH_OUTPUT_ON,
    OP_LATCH_OUTPUT_OFF, OP_RISING_PULSE, OP_FALLING_PULSE, OP_MASTER_GATE_BEGIN,
    OP_MASTER_GATE_END, OP_SEQUENTIAL_STEP_ADVANCE, OP_EXCLUSIVE_STEP_SELECT,
    OP_ON_DELAY_FINE, OP_ON_DELAY_COARSE, OP_OFF_DELAY_FINE, OP_OFF_DELAY_COARSE,
    OP_RETENTIVE_ON_DELAY_FINE, OP_RETENTIVE_ON_DELAY_COARSE, OP_UP_COUNT_OP,
    OP_DOWN_COUNT_OP
  } lsf_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LATCH, ST_EXEC, ST_FINISH} lsf_fsm_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lsf_bus_t;

  typedef struct packed {
    lsf_fsm_t                      st;
    logic [PC_W-1:0]               pc;
    logic                          acc;
    logic                          blk;
    logic [GATE_N-1:0]             gate;
    logic [BIT_N-1:0]              bits;
    logic [PROG_N-1:0]             prev;
    logic [TMR_N-1:0]              tdone;
    logic [TMR_N-1:0]              tvalid;
    logic [CNT_N-1:0][15:0]        cval;
    logic [CNT_N-1:0]              cdone;
    logic [CNT_N-1:0]              cprev;
    logic [REL_N-1:0]              son;
    logic [REL_N-1:0][7:0]         snum;
    logic                          run;
    logic                          scan_pend;
    logic                          fine_pend;
    logic                          coarse_pend;
    logic [31:0]                   scan_div;
    logic [31:0]                   fine_div;
    logic [31:0]                   coarse_div;
    logic [15:0]                   scans;
    logic [PIN_N-1:0]              pin_s1;
    logic [PIN_N-1:0]              pin_s2;
    logic [PIN_N-1:0]              pin_out;
    logic [31:0]                   rdata;
  } lsf_state_t;

endpackage

// [verification/lsf_checker.sv]
`timescale 1ns/1ps

module lsf_checker
  import lsf_pkg::*;
(
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst_n,
  // register port
  input wire logic [15:0]      addr,
  input wire logic [31:0]      wdata,
  input wire logic             wr,
  input wire logic             rd,
  input wire logic [31:0]      rdata,
  // pins and status
  input wire logic [PIN_N-1:0] pin_in,
  input wire logic [PIN_N-1:0] pin_out,
  input wire logic             scan_busy
);
  logic [8:0] busy_cnt_r;

  // ****
  // scan length counter
  // ****
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt_r <= 9'h000;
    else if (scan_busy)
      busy_cnt_r <= busy_cnt_r + 9'h001;
    else
      busy_cnt_r <= 9'h000;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_pins_at_end: assert property ($changed(pin_out) |-> $past(scan_busy))
    else $error("pin_out changed outside a scan");
  a_scan_min_len: assert property (
    $fell(scan_busy) |-> $past(scan_busy, 2) && $past(scan_busy, 3))
    else $error("scan shorter than three cycles");
  a_scan_max_len: assert property (busy_cnt_r <= 9'h102)
    else $error("scan longer than 258 cycles");
  a_once_starts: assert property (
    wr && addr == ADDR_CTRL && wdata[CTRL_ONCE] |-> ##[1:3] scan_busy)
    else $error("scan request not taken");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == RDATA_RST)
    else $error("read data outside its cycle");
  a_bit_readback: assert property (
    wr && addr == 16'h0808 && !scan_busy ##1 rd && addr == 16'h0808 && !scan_busy
    |=> rdata[15:0] == $past(wdata[15:0], 2))
    else $error("bit word readback wrong");
  a_tmr_done_zero: assert property (
    rd && addr[15:8] == PAGE_TMR |=> !rdata[16] || rdata[15:0] == 16'h0000)
    else $error("timer done with nonzero value");
  a_word_width: assert property (
    rd && (addr[15:8] == PAGE_TMR || addr[15:8] == PAGE_CNT) |=> rdata[31:17] == 15'h0000)
    else $error("timer or counter word too wide");
  a_step_field: assert property (
    rd && addr[15:8] == PAGE_STEP |=> rdata[31:9] == 23'h000000)
    else $error("step word too wide");
endmodule

bind lsf_ladder_unit lsf_checker u_chk (
  .mclk      (mclk),
  .rst_n     (rst_n),
  .addr      (addr),
  .wdata     (wdata),
  .wr        (wr),
  .rd        (rd),
  .rdata     (rdata),
  .pin_in    (pin_in),
  .pin_out   (pin_out),
  .scan_busy (scan_busy)
);

// [verification/testbench.sv]
`timescale 1ns/1ps

module testbench
  import lsf_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic        scan_busy;
  int          fail_count;
  int          checks;
  int          nscan;
  logic        lat;
  logic        prv6;
  logic        cprv;
  logic [15:0] cnt;
  logic [15:0] p;
  logic [31:0] rv;
  logic [31:0] prog [0:50];
  logic [15:0] cor [0:2] = '{16'h0380, 16'h0280, 16'h0C50};
  logic [31:0] sv [0:4] = '{32'h2, 32'h1, 32'h2, 32'h4, 32'h8};
  logic [15:0] sa [0:4] = '{16'h0E00, 16'h0E00, 16'h0E00, 16'h0E04, 16'h0E04};
  logic [31:0] se [0:4] = '{32'h0, 32'h100, 32'h101, 32'h105, 32'h109};

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  lsf_ladder_unit #(
    .SCAN_CYCLES   (40),
    .FINE_CYCLES   (20),
    .COARSE_CYCLES (200)
  ) uut (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .addr      (addr),
    .wdata     (wdata),
    .wr        (wr),
    .rd        (rd),
    .rdata     (rdata),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .scan_busy (scan_busy)
  );

  // ****
  // helpers
  // ****
  function automatic logic [31:0] ins(input int op, input int idx, input int aux);
    return {op[4:0], idx[10:0], aux[15:0]};
  endfunction

  function automatic logic [15:0] model(input logic [15:0] v);
    logic [15:0] e;
    e = 16'h0000;
    e[0] = (v[0] & v[1]) | ~v[2];
    e[1] = v[3];
    if (v[4])
      lat = 1'b1;
    if (v[5])
      lat = 1'b0;
    e[2] = lat;
    e[3] = v[6] & ~prv6;
    e[4] = ~v[6] & prv6;
    prv6 = v[6];
    e[5] = v[7] & v[8] & v[9];
    e[6] = v[9];
    e[7] = v[3];
    if (v[11])
      cnt = 16'h0000;
    else if (v[10] & ~cprv)
      cnt = cnt + 16'h0001;
    cprv = v[10];
    e[8] = cnt >= 16'h0003;
    return e;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bw(input logic [15:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    // strobe held for back-to-back writes, caller releases
    @(posedge mclk);
  endtask

  task automatic br(input logic [15:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    wr   <= 1'b0;
    @(posedge mclk);
    rd   <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic scan(input logic [15:0] v);
    int n;
    n = 0;
    wr <= 1'b0;
    pin_in <= v;
    repeat (4) @(posedge mclk);
    bw(ADDR_CTRL, 32'h0000_0002);
    wr <= 1'b0;
    while (scan_busy !== 1'b1 && n < 10)
    begin
      @(posedge mclk);
      n++;
    end
    while (scan_busy !== 1'b0 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    chk("scan_busy", 32'h0, {31'h0, scan_busy});
    nscan++;
    repeat (25) @(posedge mclk);
    chk("pin_out", {16'h0, model(v)}, {16'h0, pin_out & 16'hF9FF});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #300us;
    fail_count++;
    finish_test();
  end

  // ****
  // main sequence
  // ****
  initial
  begin
    fail_count = 0;
    checks = 0;
    nscan = 0;
    lat = 1'b0;
    prv6 = 1'b0;
    cprv = 1'b0;
    cnt = 16'h0000;
    rst_n = 1'b0;
    addr = 16'h0000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    pin_in = 16'h0000;
    void'($urandom(8743));
    prog = '{ins(1,0,0), ins(3,1,0), ins(6,2,0), ins(11,16,0), ins(2,3,0), ins(7,0,0),
      ins(11,17,0), ins(1,4,0), ins(12,18,0), ins(1,5,0), ins(13,18,0), ins(1,6,0),
      ins(14,0,0), ins(11,19,0), ins(1,6,0), ins(15,0,0), ins(11,20,0), ins(1,7,0),
      ins(16,0,0), ins(1,8,0), ins(16,1,0), ins(1,9,0), ins(11,21,0), ins(17,0,0),
      ins(1,9,0), ins(11,22,0), ins(1,17,0), ins(11,23,0), ins(1,11,0), ins(8,0,0),
      ins(1,10,0), ins(26,0,3), ins(1,1040,0), ins(11,24,0), ins(1,48,0), ins(18,0,0),
      ins(1,49,0), ins(18,0,1), ins(1,50,0), ins(19,1,5), ins(1,51,0), ins(19,1,9),
      ins(1,12,0), ins(20,0,2), ins(1,1024,0), ins(11,25,0), ins(1,13,0), ins(22,1,2),
      ins(1,1025,0), ins(11,26,0), ins(0,0,0)};
    repeat (10) @(posedge mclk);
    chk("reset", 32'h0, {rdata[15:0], pin_out} | {31'h0, scan_busy});
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 51; i++)
      bw(16'h0400 + 16'(4 * i), prog[i]);
    p = $urandom;
    bw(16'h0808, {16'h0, p});
    br(16'h0808, rv);
    chk("bit word", {16'h0, p}, {16'h0, rv[15:0]});
    br(16'h0FF0, rv);
    chk("unmapped", 32'h0, rv);
    $display("test bus done");
    for (int i = 0; i < 40; i++)
    begin
      p = (i < 3) ? cor[i] : 16'($urandom);
      p[11] = ($urandom % 6) == 0;
      p[12] = 1'b0;
      scan(p);
    end
    br(16'h0D00, rv);
    chk("counter", {15'h0, cnt >= 16'h0003, cnt}, rv);
    $display("test logic done");
    for (int i = 0; i < 5; i++)
    begin
      bw(16'h080C, sv[i]);
      scan(16'h0000);
      br(sa[i], rv);
      chk("step", se[i], rv);
    end
    $display("test steps done");
    scan(16'h1000);
    chk("timer early", 32'h0, {31'h0, pin_out[9]});
    scan(16'h1000);
    scan(16'h1000);
    chk("timer done", 32'h1, {31'h0, pin_out[9]});
    scan(16'h0000);
    br(16'h0C00, rv);
    chk("timer reload", 32'h2, rv | {31'h0, pin_out[9]});
    scan(16'h2000);
    chk("off-delay on", 32'h1, {31'h0, pin_out[10]});
    scan(16'h0000);
    chk("off-delay hold", 32'h1, {31'h0, pin_out[10]});
    scan(16'h0000);
    chk("off-delay end", 32'h0, {31'h0, pin_out[10]});
    $display("test timer done");
    br(ADDR_STATUS, rv);
    chk("status", {16'(nscan), 16'h0}, rv);
    bw(ADDR_CTRL, 32'h0000_0001);
    wr <= 1'b0;
    repeat (200) @(posedge mclk);
    bw(ADDR_CTRL, 32'h0000_0000);
    wr <= 1'b0;
    repeat (150) @(posedge mclk);
    br(ADDR_STATUS, rv);
    chk("periodic busy", 32'h0, {31'h0, rv[0]});
    chk("periodic scans", 32'h1, {31'h0, rv[31:16] >= 16'(nscan + 2)});
    $display("test status done");
    finish_test();
  end
endmodule
